// [asp_pkg.sv]
// Functional notes
// - output bits change on falling serial clock
// - data-out tristated while chip select high
// - idle selected line low signals fresh result
// - unread result: ready returns high before update
// - input bits captured on rising serial clock
// - input word written to addressed mode or io config register
// - any register loadable into output shifter
// - works with chip select tied low
// - low error input sets external error bit
// - error flags drive open-drain error pin
// - output mode pin follows fault data bit
// - output mode pin drives both levels
// - power-down switch follows its config bit
// - clock pin direction follows clock select
package asp_pkg;
    // register addresses
    localparam logic [5:0] ADDR_STATUS = 6'h00;
    localparam logic [5:0] ADDR_MODE = 6'h01;
    localparam logic [5:0] ADDR_DATA = 6'h04;
    localparam logic [5:0] ADDR_IOCFG = 6'h06;
    // communications byte fields
    localparam int COMMS_WEN_BIT = 7;
    localparam int COMMS_READ_BIT = 6;
    // converter mode register fields
    localparam int MODE_CLKSEL_LSB = 2;
    // io config register fields
    localparam int IOCFG_POWER_DOWN_SWITCH_BIT = 14;
    localparam int IOCFG_ERRMODE_LSB = 4;
    localparam int IOCFG_ERRDAT_BIT = 3;
    // status register fields
    localparam int STAT_RDYN_BIT = 7;
    localparam int STAT_EXTERR_BIT = 6;
    localparam int STAT_INTERR_LSB = 4;
    // reset values and widths
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] IOCFG_RESET = 16'h0000;
    localparam logic [23:0] DATA_RESET = 24'h000000;
    localparam int DATA_W = 24;
    localparam int BUF_DEPTH = 2;
    // serial word lengths in bits
    localparam logic [4:0] BITS_BYTE = 5'h08;
    localparam logic [4:0] BITS_HALF = 5'h10;
    localparam logic [4:0] BITS_WORD = 5'h18;

    typedef enum logic [1:0] {ERRM_OFF, ERRM_INPUT, ERRM_ODRAIN, ERRM_GPO} asp_errmode_t;
    typedef enum logic [1:0] {CLK_INT, CLK_INT_OUT, CLK_EXT_IN, CLK_XTAL} asp_clksel_t;

    // one driven pin: level and output enable
    typedef struct packed {
        logic o;
        logic oe;
    } asp_pin_t;
endpackage : asp_pkg

// [asp_serial_port.sv]
`timescale 1ns/1ps
module asp_serial_port (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial port pins
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    output asp_pkg::asp_pin_t doutPin,
    // error pin
    input wire logic faultPinIn,
    output asp_pkg::asp_pin_t faultPin,
    // clock pin and power-down switch
    input wire logic oscClk,
    output asp_pkg::asp_pin_t clockPin,
    output logic extClockSelect,
    output logic crystalEnable,
    output logic powerDownSwitch,
    // conversion results
    input wire logic resultValid,
    input wire logic [asp_pkg::DATA_W-1:0] resultData,
    output logic resultReady,
    // internal error flags
    input wire logic [1:0] internalError
);
    import asp_pkg::*;

    typedef enum logic [1:0] {ST_COMMS, ST_WRITE, ST_READ} asp_state_t;

    // pin synchronisers: {osc, fault, din, sclk, cs}
    logic [4:0] syncA_reg;
    logic [4:0] syncB_reg;
    logic sclkLast_reg;
    wire csLow = !syncB_reg[0];
    wire sclkS = syncB_reg[1];
    wire dinS = syncB_reg[2];
    wire faultS = syncB_reg[3];
    wire oscS = syncB_reg[4];
    wire sclkRise = sclkS && !sclkLast_reg;
    wire sclkFall = !sclkS && sclkLast_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncA_reg <= 5'h0B;
            syncB_reg <= 5'h0B;
            sclkLast_reg <= 1'b1;
        end else begin
            syncA_reg <= {oscClk, faultPinIn, din, sclk, csN};
            syncB_reg <= syncA_reg;
            sclkLast_reg <= syncB_reg[1];
        end
    end

    // serial engine state
    asp_state_t stateReg;
    asp_state_t stateNext;
    logic [5:0] addr_reg;
    logic [4:0] bitCnt_reg;
    logic [DATA_W-1:0] rxShift_reg;
    logic [DATA_W-1:0] txShift_reg;
    logic [15:0] mode_reg;
    logic [15:0] ioCfg_reg;
    logic [DATA_W-1:0] data_reg;
    logic fresh_reg;
    logic extErr_reg;
    logic [1:0] intErr_reg;

    function automatic logic [4:0] regBits(input logic [5:0] a);
        case (a)
            ADDR_MODE: regBits = BITS_HALF;
            ADDR_IOCFG: regBits = BITS_HALF;
            ADDR_DATA: regBits = BITS_WORD;
            default: regBits = BITS_BYTE;
        endcase
    endfunction : regBits

    wire [DATA_W-1:0] rxNext = {rxShift_reg[DATA_W-2:0], dinS};
    wire [4:0] wordBits = (stateReg == ST_COMMS) ? BITS_BYTE : regBits(addr_reg);
    wire byteDone = sclkRise && csLow && (bitCnt_reg == wordBits - 5'h01);
    wire commsDone = byteDone && (stateReg == ST_COMMS);
    wire commsTaken = commsDone && !rxNext[COMMS_WEN_BIT];
    wire startRead = commsTaken && rxNext[COMMS_READ_BIT];
    wire [5:0] newAddr = rxNext[5:0];
    wire writeCommit = byteDone && (stateReg == ST_WRITE);
    wire startDataRead = startRead && (newAddr == ADDR_DATA);
    wire statusRead = startRead && (newAddr == ADDR_STATUS);
    wire readingData = (stateReg == ST_READ) && (addr_reg == ADDR_DATA);

    // decoded configuration
    wire asp_errmode_t errMode = asp_errmode_t'(ioCfg_reg[IOCFG_ERRMODE_LSB +: 2]);
    wire asp_clksel_t clkSel = asp_clksel_t'(mode_reg[MODE_CLKSEL_LSB +: 2]);

    // status byte assembly
    logic [7:0] statusByte;
    always_comb begin
        statusByte = 8'h00;
        statusByte[STAT_RDYN_BIT] = !fresh_reg;
        statusByte[STAT_EXTERR_BIT] = extErr_reg;
        statusByte[STAT_INTERR_LSB +: 2] = intErr_reg;
    end

    // read source, left aligned so the msb leaves first
    wire [DATA_W-1:0] readWord =
        (newAddr == ADDR_STATUS) ? {statusByte, 16'h0000} :
        (newAddr == ADDR_MODE) ? {mode_reg, 8'h00} :
        (newAddr == ADDR_IOCFG) ? {ioCfg_reg, 8'h00} :
        (newAddr == ADDR_DATA) ? data_reg : 24'h000000;

    // next state: a byte count ends each transfer, chip select only aborts
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            ST_COMMS: begin
                if (commsTaken) begin
                    stateNext = rxNext[COMMS_READ_BIT] ? ST_READ : ST_WRITE;
                end
            end
            ST_WRITE, ST_READ: begin
                if (byteDone) begin
                    stateNext = ST_COMMS;
                end
            end
            default: stateNext = ST_COMMS;
        endcase
        if (!csLow) begin
            stateNext = ST_COMMS;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stateReg <= ST_COMMS;
            addr_reg <= 6'h00;
            bitCnt_reg <= 5'h00;
            rxShift_reg <= 24'h000000;
        end else begin
            stateReg <= stateNext;
            if (commsTaken) begin
                addr_reg <= newAddr;
            end
            if (!csLow || byteDone) begin
                bitCnt_reg <= 5'h00;
            end else if (sclkRise) begin
                bitCnt_reg <= bitCnt_reg + 5'h01;
            end
            if (sclkRise && csLow) begin
                rxShift_reg <= rxNext;
            end
        end
    end

    // register writes; status and data are read only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= MODE_RESET;
            ioCfg_reg <= IOCFG_RESET;
        end else if (writeCommit) begin
            if (addr_reg == ADDR_MODE) begin
                mode_reg <= rxNext[15:0];
            end
            if (addr_reg == ADDR_IOCFG) begin
                ioCfg_reg <= rxNext[15:0];
            end
        end
    end

    // output shifter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txShift_reg <= 24'h000000;
        end else if (startRead) begin
            txShift_reg <= readWord;
        end else if (stateReg == ST_READ && sclkFall) begin
            txShift_reg <= {txShift_reg[DATA_W-2:0], 1'b0};
        end
    end

    // two-entry result buffer
    logic [DATA_W-1:0] bufMem_reg [BUF_DEPTH];
    logic bufWp_reg;
    logic bufRp_reg;
    logic [1:0] bufCnt_reg;
    logic bufReady_reg;
    wire bufValid = (bufCnt_reg != 2'h0);
    wire bufPush = resultValid && bufReady_reg;
    wire loadData = bufValid && !fresh_reg && !readingData && !startDataRead;
    wire dropFresh = bufValid && fresh_reg && !readingData;
    wire [1:0] bufCntNext = bufCnt_reg + {1'b0, bufPush} - {1'b0, loadData};

    for (genvar g = 0; g < BUF_DEPTH; g++) begin : gBuf
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                bufMem_reg[g] <= DATA_RESET;
            end else if (bufPush && bufWp_reg == 1'(g)) begin
                bufMem_reg[g] <= resultData;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bufWp_reg <= 1'b0;
            bufRp_reg <= 1'b0;
            bufCnt_reg <= 2'h0;
            bufReady_reg <= 1'b1;
        end else begin
            bufWp_reg <= bufWp_reg ^ bufPush;
            bufRp_reg <= bufRp_reg ^ loadData;
            bufCnt_reg <= bufCntNext;
            bufReady_reg <= (bufCntNext != 2'h2);
        end
    end

    // result register and its fresh flag; an unread result is withdrawn first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_reg <= DATA_RESET;
            fresh_reg <= 1'b0;
        end else begin
            if (loadData) begin
                data_reg <= bufMem_reg[bufRp_reg];
                fresh_reg <= 1'b1;
            end else if (dropFresh || startDataRead) begin
                fresh_reg <= 1'b0;
            end
        end
    end

    // sticky error flags, set wins over the clear by a status read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            extErr_reg <= 1'b0;
            intErr_reg <= 2'h0;
        end else begin
            extErr_reg <= ((errMode == ERRM_INPUT) && !faultS)
                || (extErr_reg && !statusRead);
            intErr_reg <= internalError | (intErr_reg & {2{!statusRead}});
        end
    end

    // pin drivers
    asp_pin_t doutPin_reg;
    asp_pin_t faultPin_reg;
    asp_pin_t clockPin_reg;
    logic extClk_reg;
    logic xtal_reg;
    logic power_down_switch_reg;
    wire errAny = extErr_reg || (intErr_reg != 2'h0);
    wire faultOut = (errMode == ERRM_GPO) && ioCfg_reg[IOCFG_ERRDAT_BIT];
    wire faultOe = (errMode == ERRM_GPO) || ((errMode == ERRM_ODRAIN) && errAny);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            doutPin_reg <= '{o: 1'b1, oe: 1'b0};
        end else begin
            doutPin_reg.oe <= csLow;
            if (stateReg != ST_READ) begin
                doutPin_reg.o <= !fresh_reg;
            end else if (sclkFall) begin
                doutPin_reg.o <= txShift_reg[DATA_W-1];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            faultPin_reg <= '{o: 1'b0, oe: 1'b0};
            clockPin_reg <= '{o: 1'b0, oe: 1'b0};
            extClk_reg <= 1'b0;
            xtal_reg <= 1'b0;
            power_down_switch_reg <= 1'b0;
        end else begin
            faultPin_reg <= '{o: faultOut, oe: faultOe};
            clockPin_reg <= '{o: oscS, oe: clkSel == CLK_INT_OUT};
            extClk_reg <= (clkSel == CLK_EXT_IN);
            xtal_reg <= (clkSel == CLK_XTAL);
            power_down_switch_reg <= ioCfg_reg[IOCFG_POWER_DOWN_SWITCH_BIT];
        end
    end

    assign doutPin = doutPin_reg;
    assign faultPin = faultPin_reg;
    assign clockPin = clockPin_reg;
    assign extClockSelect = extClk_reg;
    assign crystalEnable = xtal_reg;
    assign powerDownSwitch = power_down_switch_reg;
    assign resultReady = bufReady_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_unread;
        fresh_reg && bufValid && !readingData;
    endsequence

    sequence s_readByte;
        stateReg == ST_READ && $past(stateReg) == ST_READ;
    endsequence

    a_dout_tristate: assert property (!csLow |=> !doutPin.oe)
        else $error("data-out driven while deselected");
    a_ready_level: assert property (csLow && stateReg != ST_READ |=> doutPin.o == !$past(fresh_reg))
        else $error("ready level wrong");
    a_data_fall: assert property (s_readByte and $changed(doutPin.o) |-> $past(sclkFall))
        else $error("data bit changed off falling edge");
    a_ready_release: assert property (s_unread |=> !fresh_reg)
        else $error("unread result not withdrawn");
    a_rx_capture: assert property (sclkRise && csLow |=> rxShift_reg[0] == $past(dinS))
        else $error("input bit not captured");
    a_write_commit: assert property (writeCommit && addr_reg == ADDR_IOCFG |=> ioCfg_reg == $past(rxNext[15:0]))
        else $error("write not committed");
    a_read_load: assert property (startDataRead |=> txShift_reg == $past(data_reg))
        else $error("result not loaded to shifter");
    a_word_end: assert property (byteDone && stateReg != ST_COMMS |=> stateReg == ST_COMMS)
        else $error("transfer did not end by count");
    a_err_input: assert property (errMode == ERRM_INPUT && !faultS |=> extErr_reg)
        else $error("error input not latched");
    a_err_odrain: assert property (errMode == ERRM_ODRAIN |=> !faultPin.o && faultPin.oe == $past(errAny))
        else $error("open-drain error pin wrong");
    a_gpo_level: assert property (errMode == ERRM_GPO |=> faultPin.o == $past(ioCfg_reg[IOCFG_ERRDAT_BIT]))
        else $error("fault pin level wrong");
    a_gpo_drive: assert property (errMode == ERRM_GPO ##1 !faultPin.o |-> faultPin.oe)
        else $error("fault pin not driven");
    a_power_down_switch_follow: assert property (1'b1 |=> powerDownSwitch == $past(ioCfg_reg[IOCFG_POWER_DOWN_SWITCH_BIT]))
        else $error("power-down switch wrong");
    a_clk_pin: assert property (clkSel != CLK_INT_OUT |=> !clockPin.oe && extClockSelect == $past(clkSel == CLK_EXT_IN))
        else $error("clock pin direction wrong");
endmodule : asp_serial_port

// [asp_host_model.sv]
`timescale 1ns/1ps
module asp_host_model (
    // clock reference
    input wire logic clk,
    // serial pins
    output logic csN,
    output logic sclk,
    output logic din,
    input wire logic doutWire
);
    initial begin
        csN = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end

    // half of a 32 ns link clock period
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask : half

    task automatic bit_io(input logic b, output logic r);
        sclk = 1'b0;
        din = b;
        half();
        r = doutWire;
        sclk = 1'b1;
        half();
    endtask : bit_io

    task automatic xfer(input logic [7:0] comms, input logic [4:0] n, input logic [23:0] wr,
                        output logic [23:0] rd, input logic keepCs);
        logic r;
        logic [23:0] w;
        rd = 24'h000000;
        w = wr << (24 - int'(n));
        @(posedge clk);
        #1;
        csN = 1'b0;
        half();
        for (int i = 7; i >= 0; i--) bit_io(comms[i], r);
        for (int i = 0; i < int'(n); i++) begin
            bit_io(w[23], r);
            w = w << 1;
            rd = {rd[22:0], r};
        end
        if (!keepCs) csN = 1'b1;
        half();
    endtask : xfer

    // ready falling edge used as an interrupt
    task automatic wait_ready(output logic seen);
        seen = 1'b0;
        csN = 1'b0;
        // the line floats until the output enable has passed the synchronisers
        repeat (4) @(posedge clk);
        repeat (200) begin
            @(posedge clk);
            #1;
            if (doutWire === 1'b0) begin
                seen = 1'b1;
                break;
            end
        end
    endtask : wait_ready
endmodule : asp_host_model

// [asp_serial_port_test.sv]
`timescale 1ns/1ps
module asp_serial_port_test;
    import asp_pkg::*;
    logic clk, resetn, csN, sclk, din, faultPinIn, oscClk, extClockSelect, crystalEnable;
    logic powerDownSwitch, resultValid, resultReady, extFaultN, lastDout, doutWire, seen;
    logic [DATA_W-1:0] resultData;
    logic [1:0] internalError;
    logic [23:0] rd;
    logic [2:0] oscHist;
    asp_pin_t doutPin, faultPin, clockPin;
    int fails, checks_done, cycles;

    // a released line shows the inverse of its last driven level
    always @(posedge clk) if (doutPin.oe) lastDout <= doutPin.o;
    // oscillator level as seen one, two and three edges back, for the clock pin mirror
    always @(posedge clk) oscHist <= {oscHist[1:0], oscClk};
    assign doutWire = doutPin.oe ? doutPin.o : ~lastDout;
    // pulled-up shared error line, another device may pull it low
    assign faultPinIn = (faultPin.oe ? faultPin.o : 1'b1) & extFaultN;

    asp_serial_port i_asp_serial_port (.clk(clk), .resetn(resetn), .csN(csN), .sclk(sclk),
        .din(din), .doutPin(doutPin), .faultPinIn(faultPinIn), .faultPin(faultPin),
        .oscClk(oscClk), .clockPin(clockPin), .extClockSelect(extClockSelect),
        .crystalEnable(crystalEnable), .powerDownSwitch(powerDownSwitch),
        .resultValid(resultValid), .resultData(resultData), .resultReady(resultReady),
        .internalError(internalError));
    asp_host_model i_asp_host_model (.clk(clk), .csN(csN), .sclk(sclk), .din(din),
        .doutWire(doutWire));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        oscClk = 1'b0;
        // offset keeps oscillator edges away from system clock edges
        #0.3;
        forever #7 oscClk = ~oscClk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [5:0] a, input logic [4:0] n, input logic [23:0] v);
        logic [23:0] dummy;
        i_asp_host_model.xfer({2'b00, a}, n, v, dummy, 1'b0);
    endtask : reg_wr

    task automatic reg_rd(input logic [5:0] a, input logic [4:0] n);
        i_asp_host_model.xfer({2'b01, a}, n, 24'h000000, rd, 1'b0);
    endtask : reg_rd

    task automatic push(input logic [23:0] v);
        logic r;
        @(posedge clk);
        #1;
        resultValid = 1'b1;
        resultData = v;
        do begin
            r = resultReady;
            @(posedge clk);
        end while (r !== 1'b1);
        #1;
        resultValid = 1'b0;
    endtask : push

    initial begin
        resetn = 1'b0;
        resultValid = 1'b0;
        resultData = 24'h000000;
        internalError = 2'h0;
        extFaultN = 1'b1;
        lastDout = 1'b0;
        fails = 0;
        checks_done = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({20'h0, doutPin.oe, clockPin.oe, faultPin.oe, powerDownSwitch}, 24'h0);
        $display("test reset done");

        reg_wr(ADDR_IOCFG, BITS_HALF, 24'h004000);
        chk({23'h0, powerDownSwitch}, 24'h1);
        reg_rd(ADDR_IOCFG, BITS_HALF);
        chk(rd, 24'h004000);
        reg_wr(ADDR_IOCFG, BITS_HALF, 24'h000000);
        chk({23'h0, powerDownSwitch}, 24'h0);
        $display("test power switch done");

        for (int i = 0; i < 4; i++) begin
            reg_wr(ADDR_MODE, BITS_HALF, 24'(i << MODE_CLKSEL_LSB));
            chk({21'h0, clockPin.oe, extClockSelect, crystalEnable},
                {21'h0, i == 1, i == 2, i == 3});
            reg_rd(ADDR_MODE, BITS_HALF);
            chk(rd, 24'(i << MODE_CLKSEL_LSB));
            if (i == 1) begin
                repeat (8) begin
                    @(posedge clk);
                    #1;
                    chk({23'h0, clockPin.o}, {23'h0, oscHist[2]});
                end
            end
        end
        $display("test clock select done");

        push(24'hA5C3E1);
        i_asp_host_model.wait_ready(seen);
        chk({23'h0, seen}, 24'h1);
        reg_rd(ADDR_DATA, BITS_WORD);
        chk(rd, 24'hA5C3E1);
        repeat (2) @(posedge clk);
        #1;
        chk({23'h0, doutPin.oe}, 24'h0);
        $display("test result read done");

        push(24'h123456);
        i_asp_host_model.wait_ready(seen);
        push(24'h654321);
        seen = 1'b0;
        repeat (30) begin
            @(posedge clk);
            #1;
            if (doutWire === 1'b1) seen = 1'b1;
        end
        chk({23'h0, seen}, 24'h1);
        reg_rd(ADDR_DATA, BITS_WORD);
        chk(rd, 24'h654321);
        $display("test unread result done");

        push(24'h0F0F0F);
        i_asp_host_model.wait_ready(seen);
        i_asp_host_model.xfer(8'h44, BITS_WORD, 24'h0, rd, 1'b1);
        chk(rd, 24'h0F0F0F);
        i_asp_host_model.xfer(8'h46, BITS_HALF, 24'h0, rd, 1'b1);
        chk(rd, 24'h000000);
        reg_rd(ADDR_MODE, BITS_HALF);
        chk(rd, 24'h00000C);
        $display("test three wire done");

        fork
            reg_rd(ADDR_DATA, BITS_WORD);
            begin
                repeat (100) @(posedge clk);
                push(24'h000011);
                push(24'h000022);
                push(24'h000033);
            end
            begin
                seen = 1'b0;
                repeat (250) begin
                    @(posedge clk);
                    #1;
                    if (resultReady === 1'b0) seen = 1'b1;
                end
            end
        join
        chk(rd, 24'h0F0F0F);
        chk({23'h0, seen}, 24'h1);
        reg_rd(ADDR_DATA, BITS_WORD);
        chk(rd, 24'h000033);
        $display("test buffer done");

        reg_wr(ADDR_IOCFG, BITS_HALF, 24'h000010);
        extFaultN = 1'b0;
        repeat (5) @(posedge clk);
        reg_rd(ADDR_STATUS, BITS_BYTE);
        chk({23'h0, rd[STAT_EXTERR_BIT]}, 24'h1);
        extFaultN = 1'b1;
        reg_rd(ADDR_STATUS, BITS_BYTE);
        reg_wr(ADDR_IOCFG, BITS_HALF, 24'h000020);
        chk({23'h0, faultPin.oe}, 24'h0);
        internalError = 2'h1;
        @(posedge clk);
        #1;
        internalError = 2'h0;
        repeat (3) @(posedge clk);
        #1;
        chk({22'h0, faultPin.o, faultPin.oe}, 24'h1);
        chk({23'h0, faultPinIn}, 24'h0);
        reg_wr(ADDR_IOCFG, BITS_HALF, 24'h000038);
        chk({22'h0, faultPin.o, faultPin.oe}, 24'h3);
        reg_wr(ADDR_IOCFG, BITS_HALF, 24'h000030);
        chk({22'h0, faultPin.o, faultPin.oe}, 24'h1);
        $display("test error pin done");
        finish_test();
    end
endmodule : asp_serial_port_test
